// File: remote_interface_config_consts.svh
/*
 * Constants of the remote interface configuration block: bit positions,
 * reset value, memory select codes and boot strap settle cycles.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef REMOTE_INTERFACE_CONFIG_CONSTS_SVH
`define REMOTE_INTERFACE_CONFIG_CONSTS_SVH

// configuration register bit positions
`define CFG_BIT_IRQ_STATUS   7
`define CFG_BIT_SINGLE_STEP  6
`define CFG_BIT_FAST_WRITE   5
`define CFG_BIT_LATCH_READ   4
`define CFG_BIT_LATCH_WRITE  3
`define CFG_BIT_RUN          2
`define CFG_BIT_MSEL_HI      1
`define CFG_BIT_MSEL_LO      0

// reset value: everything low, memory select pointing at instruction memory
`define CFG_RESET_VALUE      8'h01

// memory select codes
`define MSEL_DATA            2'h0
`define MSEL_INSTR           2'h1
`define MSEL_PC_LOW          2'h2
`define MSEL_PC_HIGH         2'h3

// cycles to wait after reset release before sampling the boot strap
`define STRAP_SETTLE_CYCLES  2'h3

`endif

// File: remote_cfg_pkg.sv
/*
 * Types shared by the remote interface configuration block.
 * Assumes remote_interface_config_consts.svh is on the include path.
 */
`include "remote_interface_config_consts.svh"

package remote_cfg_pkg;

    // routing target of remote accesses
    typedef enum logic [1:0] {
        TGT_DATA_MEM  = `MSEL_DATA,
        TGT_INSTR_MEM = `MSEL_INSTR,
        TGT_PC_LOW    = `MSEL_PC_LOW,
        TGT_PC_HIGH   = `MSEL_PC_HIGH
    } mem_target_t;

    // access modes handed to the remote datapath
    typedef struct packed {
        mem_target_t target;
        logic        latched_read_select;
        logic        latched_write_select;
        logic        fast_write_select;
    } remote_mode_t;

    // remote pin group, all active low except cmd_select
    typedef struct packed {
        logic cmd_select;
        logic remote_access_enable_b;
        logic remote_read_strobe_b;
        logic remote_write_strobe_b;
    } remote_pins_t;

endpackage : remote_cfg_pkg

// File: data_mem_arbiter.sv
/*
 * Shared data memory arbiter between the local processor and the remote host.
 * Assumes both requests come from logic on mclk.
 */
`timescale 1ns/10ps
`default_nettype none

module data_mem_arbiter (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // requests and locks
    input  wire logic local_req,
    input  wire logic remote_req,
    input  wire logic local_lock,
    // grants
    output logic      grant_local,
    output logic      grant_remote
);
    logic last_remote;  // set when remote won the last contended cycle or the last cycle was uncontended; local wins next

    // grant: local first on contention, then alternate unless locked
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            grant_local  <= 1'b0;
            grant_remote <= 1'b0;
            last_remote  <= 1'b1;
        end else if (local_req && remote_req) begin
            if (local_lock || last_remote) begin
                grant_local  <= 1'b1;
                grant_remote <= 1'b0;
                last_remote  <= 1'b0;
            end else begin
                grant_local  <= 1'b0;
                grant_remote <= 1'b1;
                last_remote  <= 1'b1;
            end
        end else begin
            grant_local  <= local_req;
            grant_remote <= remote_req && !local_lock;
            last_remote  <= 1'b1; // fresh contention restarts with local
        end
    end

    property p_local_first;
        @(posedge mclk) disable iff (!rst_b)
        (local_req && remote_req && !$past(local_req && remote_req)) |=> grant_local;
    endproperty
    a_local_first: assert property (p_local_first)
        else $error("local did not win first contended access");

    property p_alternate;
        @(posedge mclk) disable iff (!rst_b)
        (local_req && remote_req && !local_lock)[*2] |=> (grant_local != $past(grant_local));
    endproperty
    a_alternate: assert property (p_alternate)
        else $error("contended grants did not alternate");

    c_contention: cover property (@(posedge mclk) disable iff (!rst_b)
        (local_req && remote_req)[*3]);

endmodule : data_mem_arbiter

`default_nettype wire

// File: remote_interface_config.sv
/*
 * Remote interface configuration register and processor run control.
 * Assumes remote pins are asynchronous to mclk and are synchronised here;
 * processor-side inputs are on mclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "remote_interface_config_consts.svh"

module remote_interface_config (
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst_b,
    // remote host pins
    input  wire remote_cfg_pkg::remote_pins_t remote_pins,
    input  wire logic [7:0]                 remote_data_in,
    output logic [7:0]                      remote_data_out,
    output logic                            remote_data_oe_b,
    // processor side
    input  wire logic                       local_only_request,
    input  wire logic                       ext_irq_mask_three,
    input  wire logic                       bidir_irq_is_output,
    input  wire logic                       instr_boundary,
    input  wire logic                       local_mem_req,
    input  wire logic                       remote_mem_req,
    // control outputs
    output remote_cfg_pkg::remote_mode_t    remote_mode,
    output logic                            fast_write_active,
    output logic                            cpu_run,
    output logic                            cpu_step,
    output logic                            cpu_idle,
    output logic                            bidir_irq_toggle,
    output logic                            grant_local,
    output logic                            grant_remote
);
    import remote_cfg_pkg::*;

    remote_pins_t pins_s1;
    remote_pins_t pins_s2;
    remote_pins_t pins_d;
    logic [7:0]   data_s1;
    logic [7:0]   data_s2;
    logic [7:0]   remote_config_reg;
    logic         step_pending;
    logic [1:0]   strap_count;
    logic         strap_done;
    logic         reg_selected;
    logic         reg_write;
    logic         reg_read;

    // two-flop synchronisers for pins and data
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pins_s1 <= '{1'b0, 1'b1, 1'b1, 1'b1};
            pins_s2 <= '{1'b0, 1'b1, 1'b1, 1'b1};
            pins_d  <= '{1'b0, 1'b1, 1'b1, 1'b1};
            data_s1 <= 8'h00;
            data_s2 <= 8'h00;
        end else begin
            pins_s1 <= remote_pins;
            pins_s2 <= pins_s1;
            pins_d  <= pins_s2;
            data_s1 <= remote_data_in;
            data_s2 <= data_s1;
        end
    end

    // register decode; write taken on falling write strobe
    assign reg_selected = pins_s2.cmd_select && !pins_s2.remote_access_enable_b
                          && !local_only_request;
    assign reg_write    = reg_selected && !pins_s2.remote_write_strobe_b
                          && pins_d.remote_write_strobe_b;
    assign reg_read     = reg_selected && !pins_s2.remote_read_strobe_b;

    // boot strap caught after reset release once synchronisers settle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            strap_count <= 2'h0;
            strap_done  <= 1'b0;
        end else if (!strap_done) begin
            strap_count <= strap_count + 2'h1;
            strap_done  <= (strap_count == `STRAP_SETTLE_CYCLES);
        end
    end

    // configuration register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            remote_config_reg <= `CFG_RESET_VALUE;
        end else if (!strap_done && strap_count == `STRAP_SETTLE_CYCLES) begin
            if (!pins_s2.remote_read_strobe_b && !pins_s2.remote_write_strobe_b
                && pins_s2.remote_access_enable_b) begin
                remote_config_reg[`CFG_BIT_RUN] <= 1'b1;
            end
        end else if (reg_write) begin
            remote_config_reg[5:0] <= data_s2[5:0];
        end
    end

    // single step request held until the instruction completes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            step_pending <= 1'b0;
        end else if (reg_write && data_s2[`CFG_BIT_SINGLE_STEP]
                     && !remote_config_reg[`CFG_BIT_RUN]) begin
            step_pending <= 1'b1;
        end else if (instr_boundary) begin
            step_pending <= 1'b0;
        end
    end

    // processor run, step and idle status
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_run  <= 1'b0;
            cpu_step <= 1'b0;
            cpu_idle <= 1'b1;
        end else begin
            cpu_run  <= remote_config_reg[`CFG_BIT_RUN];
            cpu_step <= step_pending;
            // a stepped instruction ends at its boundary and leaves the processor idle
            if (remote_config_reg[`CFG_BIT_RUN] || (step_pending && !instr_boundary)) begin
                cpu_idle <= 1'b0;
            end else if (instr_boundary) begin
                cpu_idle <= 1'b1;
            end
        end
    end

    // one-cycle toggle request toward the bidirectional interrupt pin
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bidir_irq_toggle <= 1'b0;
        end else begin
            bidir_irq_toggle <= reg_write && data_s2[`CFG_BIT_IRQ_STATUS]
                                && bidir_irq_is_output;
        end
    end

    // access modes, identical for every target
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            remote_mode       <= '{TGT_INSTR_MEM, 1'b0, 1'b0, 1'b0};
            fast_write_active <= 1'b0;
        end else begin
            remote_mode.target               <= mem_target_t'(remote_config_reg[1:0]);
            remote_mode.latched_read_select  <= remote_config_reg[`CFG_BIT_LATCH_READ];
            remote_mode.latched_write_select <= remote_config_reg[`CFG_BIT_LATCH_WRITE];
            fast_write_active <= remote_config_reg[`CFG_BIT_FAST_WRITE]
                                 && !remote_config_reg[`CFG_BIT_LATCH_WRITE];
            remote_mode.fast_write_select    <= remote_config_reg[`CFG_BIT_FAST_WRITE];
        end
    end

    // read data path: live mirror in bit 7, step state in bit 6
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            remote_data_out  <= 8'h00;
            remote_data_oe_b <= 1'b1;
        end else begin
            remote_data_out  <= {ext_irq_mask_three, step_pending,
                                 remote_config_reg[5:0]};
            remote_data_oe_b <= !reg_read;
        end
    end

    // shared data memory arbitration
    data_mem_arbiter u_arbiter (
        .mclk         (mclk),
        .rst_b        (rst_b),
        .local_req    (local_mem_req),
        .remote_req   (remote_mem_req),
        .local_lock   (local_only_request),
        .grant_local  (grant_local),
        .grant_remote (grant_remote)
    );

    property p_write_locked_out;
        @(posedge mclk) disable iff (!rst_b)
        (local_only_request && strap_done) |=> $stable(remote_config_reg);
    endproperty
    a_write_locked_out: assert property (p_write_locked_out)
        else $error("register changed while locked to local");

    property p_mirror;
        @(posedge mclk) disable iff (!rst_b)
        1'b1 |=> remote_data_out[7] == $past(ext_irq_mask_three);
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("bit 7 does not mirror interrupt mask");

    property p_toggle;
        @(posedge mclk) disable iff (!rst_b)
        (reg_write && data_s2[7] && bidir_irq_is_output) |=> bidir_irq_toggle ##1 !bidir_irq_toggle;
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("interrupt toggle not a single pulse");

    property p_step;
        @(posedge mclk) disable iff (!rst_b)
        (reg_write && data_s2[6] && !remote_config_reg[2]) |=> step_pending ##1 cpu_step;
    endproperty
    a_step: assert property (p_step)
        else $error("single step not requested");

    property p_fast_write;
        @(posedge mclk) disable iff (!rst_b)
        1'b1 |=> fast_write_active == ($past(remote_config_reg[5]) && !$past(remote_config_reg[3]));
    endproperty
    a_fast_write: assert property (p_fast_write)
        else $error("fast write mode wrong");

    property p_modes;
        @(posedge mclk) disable iff (!rst_b)
        1'b1 |=> (remote_mode.latched_read_select == $past(remote_config_reg[4]))
                 && (remote_mode.latched_write_select == $past(remote_config_reg[3]));
    endproperty
    a_modes: assert property (p_modes)
        else $error("latched mode bits not followed");

    property p_run;
        @(posedge mclk) disable iff (!rst_b)
        $rose(remote_config_reg[2]) |=> cpu_run ##1 !cpu_idle;
    endproperty
    a_run: assert property (p_run)
        else $error("processor did not start");

    property p_halt;
        @(posedge mclk) disable iff (!rst_b)
        (!remote_config_reg[2] && !step_pending && instr_boundary) |=> cpu_idle;
    endproperty
    a_halt: assert property (p_halt)
        else $error("processor did not halt at boundary");

    property p_target;
        @(posedge mclk) disable iff (!rst_b)
        1'b1 |=> remote_mode.target == $past(remote_config_reg[1:0]);
    endproperty
    a_target: assert property (p_target)
        else $error("memory select not routed");

    c_write:  cover property (@(posedge mclk) disable iff (!rst_b) reg_write);
    c_read:   cover property (@(posedge mclk) disable iff (!rst_b) !remote_data_oe_b);
    c_step:   cover property (@(posedge mclk) disable iff (!rst_b) $rose(cpu_step));

endmodule : remote_interface_config

`default_nettype wire

// File: remote_host_model.sv
/*
 * Remote host model: drives the remote pin group and write data of the
 * configuration block and samples its read data.
 * Assumes one mclk; every pin change lands at a falling edge.
 */
`timescale 1ns/10ps
`default_nettype none

module remote_host_model (
    // clock
    input  wire logic                        mclk,
    // pins towards the device
    output var remote_cfg_pkg::remote_pins_t remote_pins,
    output var logic [7:0]                   remote_data_in,
    // read side from the device
    input  wire logic [7:0]                  remote_data_out,
    input  wire logic                        remote_data_oe_b
);
    import remote_cfg_pkg::*;

    logic [7:0] last_data;

    // idle: nothing selected, released data shows the inverse of the last byte
    initial begin
        remote_pins    = 4'h7;
        last_data      = 8'h00;
        remote_data_in = 8'hFF;
    end

    // one register write; only the config register is touched, never memory
    task automatic host_write(input logic [7:0] d, input logic sel);
        @(negedge mclk);
        remote_data_in = d;
        last_data      = d;
        remote_pins    = {sel, 3'h2}; // select, enable, write strobe low
        repeat (4) @(negedge mclk);
        remote_pins.remote_write_strobe_b = 1'b1;
        repeat (3) @(negedge mclk);
        remote_pins    = 4'h7;
        remote_data_in = ~last_data;
        repeat (3) @(negedge mclk);
    endtask : host_write

    // one register read, bounded wait for the device to drive the bus
    task automatic host_read(output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d  = 8'h00;
        @(negedge mclk);
        remote_pins = 4'h9; // select, enable, read strobe low
        for (int n = 0; n < 10 && ok == 1'b0; n++) begin
            @(negedge mclk);
            if (remote_data_oe_b === 1'b0) begin
                ok = 1'b1;
                d  = remote_data_out;
            end
        end
        remote_pins.remote_read_strobe_b = 1'b1;
        repeat (4) @(negedge mclk);
        remote_pins = 4'h7;
    endtask : host_read

    // stand-alone boot strap: both strobes low, enable high
    task automatic host_strap(input logic on);
        remote_pins = on ? 4'h4 : 4'h7;
    endtask : host_strap
endmodule : remote_host_model

`default_nettype wire

// File: remote_interface_config_bench.sv
/*
 * Self-checking bench of the remote interface configuration block.
 * Assumes the host model and the design files are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module remote_interface_config_bench;
    import remote_cfg_pkg::*;

    localparam logic [31:0] MODE_TAB = 32'h3B2A1120;

    logic                  mclk = 1'b0;
    logic                  rst_b = 1'b0;
    remote_pins_t          remote_pins;
    logic [7:0]            remote_data_in, remote_data_out, v;
    logic                  remote_data_oe_b, local_only_request, ext_irq_mask_three;
    logic                  bidir_irq_is_output, instr_boundary, local_mem_req, remote_mem_req;
    remote_mode_t          remote_mode;
    logic                  fast_write_active, cpu_run, cpu_step, cpu_idle;
    logic                  bidir_irq_toggle, grant_local, grant_remote;
    int                    failures = 0;
    int                    n_tests = 0;
    int                    toggle_count = 0;

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    // counts toggle pulses of the interrupt output
    always @(posedge mclk) begin
        if (bidir_irq_toggle === 1'b1) begin
            toggle_count <= toggle_count + 1;
        end
    end

    remote_host_model u_host (.mclk(mclk), .remote_pins(remote_pins),
        .remote_data_in(remote_data_in), .remote_data_out(remote_data_out),
        .remote_data_oe_b(remote_data_oe_b));

    remote_interface_config u_dut (.mclk(mclk), .rst_b(rst_b), .remote_pins(remote_pins),
        .remote_data_in(remote_data_in), .remote_data_out(remote_data_out),
        .remote_data_oe_b(remote_data_oe_b), .local_only_request(local_only_request),
        .ext_irq_mask_three(ext_irq_mask_three), .bidir_irq_is_output(bidir_irq_is_output),
        .instr_boundary(instr_boundary), .local_mem_req(local_mem_req),
        .remote_mem_req(remote_mem_req), .remote_mode(remote_mode),
        .fast_write_active(fast_write_active), .cpu_run(cpu_run), .cpu_step(cpu_step),
        .cpu_idle(cpu_idle), .bidir_irq_toggle(bidir_irq_toggle),
        .grant_local(grant_local), .grant_remote(grant_remote));

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // register read with a bounded wait; a timeout ends the run
    task automatic read_expect(input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_host.host_read(d, ok);
        if (ok !== 1'b1) begin
            failures++;
            $display("MISMATCH read handshake expected oe_b low seen timeout");
            tally_and_finish();
        end else begin
            check("config readback", exp, d);
            check("oe_b after read", 8'h01, {7'h0, remote_data_oe_b});
        end
    endtask : read_expect

    task automatic pulse_boundary;
        @(negedge mclk);
        instr_boundary = 1'b1;
        @(negedge mclk);
        instr_boundary = 1'b0;
        repeat (2) @(negedge mclk);
    endtask : pulse_boundary

    initial begin
        {local_only_request, ext_irq_mask_three, bidir_irq_is_output} = 3'h0;
        {instr_boundary, local_mem_req, remote_mem_req} = 3'h0;
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        repeat (6) @(negedge mclk);
        // reset state
        check("remote_mode", 8'h08, 8'(remote_mode));
        check("run step idle", 8'h01, {5'h0, cpu_run, cpu_step, cpu_idle});
        read_expect(8'h01);
        ext_irq_mask_three = 1'b1;
        read_expect(8'h81);
        ext_irq_mask_three = 1'b0;
        // every target with the mode bits
        for (int i = 0; i < 4; i++) begin
            v = MODE_TAB[i*8 +: 8];
            u_host.host_write(v, 1'b1);
            check("remote_mode", {3'h0, v[1:0], v[4], v[3], v[5]}, 8'(remote_mode));
            check("fast_write", {7'h0, v[5] & ~v[3]}, {7'h0, fast_write_active});
            read_expect({2'h0, v[5:0]});
        end
        u_host.host_write(8'h01, 1'b1);
        // refused writes: lock high, then command select low
        local_only_request = 1'b1;
        u_host.host_write(8'h05, 1'b1);
        check("cpu_run locked", 8'h00, {7'h0, cpu_run});
        local_only_request = 1'b0;
        u_host.host_write(8'h05, 1'b0);
        check("cpu_run unselected", 8'h00, {7'h0, cpu_run});
        // interrupt output toggle only when the pin is an output
        u_host.host_write(8'h81, 1'b1);
        check("toggles input", 8'h00, 8'(toggle_count));
        bidir_irq_is_output = 1'b1;
        u_host.host_write(8'h81, 1'b1);
        check("toggles output", 8'h01, 8'(toggle_count));
        read_expect(8'h01);
        // single step while stopped
        u_host.host_write(8'h41, 1'b1);
        check("step run", 8'h02, {6'h0, cpu_step, cpu_run});
        pulse_boundary();
        check("step done", 8'h00, {7'h0, cpu_step});
        check("step idle", 8'h01, {7'h0, cpu_idle});
        // start, then stop after the current instruction
        u_host.host_write(8'h05, 1'b1);
        check("run idle", 8'h02, {6'h0, cpu_run, cpu_idle});
        u_host.host_write(8'h01, 1'b1);
        check("stopping", 8'h00, {6'h0, cpu_run, cpu_idle});
        pulse_boundary();
        check("halted", 8'h01, {7'h0, cpu_idle});
        // simultaneous data memory requests, then locked to local
        local_mem_req  = 1'b1;
        remote_mem_req = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            check("grants", i[0] ? 8'h01 : 8'h02, {6'h0, grant_local, grant_remote});
        end
        local_only_request = 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(negedge mclk);
            check("grants locked", 8'h02, {6'h0, grant_local, grant_remote});
        end
        {local_only_request, local_mem_req, remote_mem_req} = 3'h0;
        // stand-alone boot strap through a second reset
        @(negedge mclk);
        rst_b = 1'b0;
        u_host.host_strap(1'b1);
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        repeat (8) @(negedge mclk);
        check("strap run", 8'h01, {7'h0, cpu_run});
        u_host.host_strap(1'b0);
        tally_and_finish();
    end
endmodule : remote_interface_config_bench

`default_nettype wire
